// >>> jump_unit_pkg.sv
// Constants and types shared by the jump, link and no-op execute logic
package jump_unit_pkg;
   localparam int XLEN = 32;
   localparam int INSTR_W = 32;
   localparam int REG_IDX_W = 5;
   localparam int SIGN_BIT_POS = 31;
   localparam int OPCODE_LSB = 0;
   localparam int OPCODE_W = 7;
   localparam int RD_LSB = 7;
   localparam int FUNCT3_LSB = 12;
   localparam int FUNCT3_W = 3;
   localparam int RS1_LSB = 15;
   localparam int IMM_I_LSB = 20;
   localparam logic [6:0] OPC_OP_IMM = 7'h13;
   localparam logic [6:0] OPC_JAL = 7'h6f;
   localparam logic [6:0] OPC_JALR = 7'h67;
   localparam logic [2:0] F3_ADDI = 3'h0;
   localparam logic [2:0] F3_JALR = 3'h0;
   localparam logic [31:0] INSTR_NOP = 32'h00000013;
   localparam logic [4:0] REG_ZERO = 5'h00;
   localparam logic [4:0] REG_LINK = 5'h01;
   localparam logic [4:0] REG_ALT_LINK = 5'h05;
   localparam logic [31:0] PC_STEP = 32'h00000004;
   localparam logic [31:0] PC_RESET = 32'h00000000;
   localparam logic [31:0] WORD_ZERO = 32'h00000000;

   typedef enum logic [1:0] {OP_OTHER, OP_NOP, OP_JAL, OP_JALR} op_kind_e;
endpackage : jump_unit_pkg

// >>> jump_dec_if.sv
// Interface carrying decoded fields between decoder and execute logic
`timescale 1ns/1ps
`default_nettype none
interface jump_dec_if;
   import jump_unit_pkg::*;
   op_kind_e kind;
   logic [4:0] rd;
   logic [4:0] rs1;
   logic [31:0] imm_j;
   logic [31:0] imm_i;
   logic illegal_jalr;
   modport dec (output kind, rd, rs1, imm_j, imm_i, illegal_jalr);
   modport exe (input kind, rd, rs1, imm_j, imm_i, illegal_jalr);
endinterface : jump_dec_if
`default_nettype wire

// >>> jump_decode.sv
// Combinational decoder for the no-op and both jump forms
`timescale 1ns/1ps
`default_nettype none
module jump_decode
   import jump_unit_pkg::*;
(
   // Instruction word
   input wire logic [31:0] instr,
   // Decoded fields
   jump_dec_if.dec dec
);
   logic [6:0] opc;
   logic [2:0] f3;

   assign opc = instr[OPCODE_LSB +: OPCODE_W];
   assign f3 = instr[FUNCT3_LSB +: FUNCT3_W];
   assign dec.rd = instr[RD_LSB +: REG_IDX_W];
   assign dec.rs1 = instr[RS1_LSB +: REG_IDX_W];
   // Sign taken from bit 31 for both forms
   assign dec.imm_i = {{20{instr[SIGN_BIT_POS]}}, instr[31:20]};
   assign dec.imm_j = {{12{instr[SIGN_BIT_POS]}}, instr[19:12], instr[20],
                       instr[30:21], 1'b0};
   assign dec.illegal_jalr = (opc == OPC_JALR) && (f3 != F3_JALR);

   always_comb begin
      if (instr == INSTR_NOP) begin
         dec.kind = OP_NOP;
      end else if (opc == OPC_JAL) begin
         dec.kind = OP_JAL;
      end else if (opc == OPC_JALR && f3 == F3_JALR) begin
         dec.kind = OP_JALR;
      end else begin
         dec.kind = OP_OTHER;
      end
   end
endmodule : jump_decode
`default_nettype wire

// >>> jump_link_nop_unit.sv
// Execute stage for the canonical no-op and the two jump-and-link forms
`timescale 1ns/1ps
`default_nettype none
module jump_link_nop_unit
   import jump_unit_pkg::*;
(
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RESET,
   // Configuration
   input wire logic HALF_ALIGN_EN,
   // Issued instruction
   input wire logic ISSUE_VALID,
   input wire logic [31:0] ISSUE_PC,
   input wire logic [31:0] ISSUE_INSTR,
   input wire logic [31:0] RS1_DATA,
   // Register write-back
   output logic WB_EN,
   output logic [4:0] WB_RD,
   output logic [31:0] WB_DATA,
   // Program counter redirect
   output logic RETIRE,
   output logic REDIRECT,
   output logic [31:0] NEXT_PC,
   output logic FLUSH_YOUNGER,
   output logic IS_NOP,
   // Exception
   output logic MISALIGN_EXC,
   output logic [31:0] MISALIGN_ADDR,
   // Target fetch fault
   input wire logic TGT_FETCH_FAULT,
   input wire logic TGT_PAGE_FAULT,
   output logic TGT_FAULT_EXC,
   output logic [31:0] TGT_FAULT_PC,
   // Return stack hints
   output logic RAS_PUSH,
   output logic RAS_POP,
   output logic [31:0] RAS_ADDR
);

   // ------------------------------------------------------------
   // Decode and address arithmetic
   // ------------------------------------------------------------
   jump_dec_if dif ();

   jump_decode u_dec (
      .instr(ISSUE_INSTR),
      .dec(dif.dec)
   );

   function automatic logic is_link(input logic [4:0] r);
      return (r == REG_LINK) || (r == REG_ALT_LINK);
   endfunction : is_link

   function automatic logic misaligned(input logic [31:0] a, input logic half);
      return !half && (a[1:0] != 2'b00);
   endfunction : misaligned

   logic [31:0] link_val;
   logic [31:0] jal_tgt;
   logic [31:0] jalr_sum;
   logic [31:0] jalr_tgt;
   logic [31:0] tgt;
   logic is_jump;
   logic exc;
   logic push_h;
   logic pop_h;
   logic half_q;
   logic pending_tgt_q;
   logic [31:0] pending_pc_q;

   assign link_val = ISSUE_PC + PC_STEP;
   assign jal_tgt = ISSUE_PC + dif.imm_j;
   // rs1 sampled before any write-back, so rd == rs1 is safe
   assign jalr_sum = RS1_DATA + dif.imm_i;
   assign jalr_tgt = {jalr_sum[31:1], 1'b0};
   assign is_jump = (dif.kind == OP_JAL) || (dif.kind == OP_JALR);
   assign tgt = (dif.kind == OP_JAL) ? jal_tgt : jalr_tgt;
   assign exc = ISSUE_VALID && is_jump && misaligned(tgt, half_q);

   // Hint logic sees only the decoded kind and register numbers; never feeds pc or data
   always_comb begin
      push_h = 1'b0;
      pop_h = 1'b0;
      case (dif.kind)
         OP_JAL: begin
            push_h = is_link(dif.rd);
         end
         OP_JALR: begin
            push_h = is_link(dif.rd);
            pop_h = is_link(dif.rs1) &&
                    (!is_link(dif.rd) || dif.rd != dif.rs1);
         end
         default: begin
            push_h = 1'b0;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Configuration capture
   // ------------------------------------------------------------
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         half_q <= 1'b0;
      end else begin
         half_q <= HALF_ALIGN_EN;
      end
   end

   // ------------------------------------------------------------
   // Write-back
   // ------------------------------------------------------------
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         WB_EN <= 1'b0;
         WB_RD <= REG_ZERO;
         WB_DATA <= WORD_ZERO;
      end else begin
         // No-op and x0 destinations write nothing; trapping jumps neither
         WB_EN <= ISSUE_VALID && is_jump && !exc &&
                  (dif.rd != REG_ZERO);
         WB_RD <= dif.rd;
         WB_DATA <= link_val;
      end
   end

   // ------------------------------------------------------------
   // Program counter and exceptions
   // ------------------------------------------------------------
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         RETIRE <= 1'b0;
         REDIRECT <= 1'b0;
         NEXT_PC <= PC_RESET;
         FLUSH_YOUNGER <= 1'b0;
         IS_NOP <= 1'b0;
         MISALIGN_EXC <= 1'b0;
         MISALIGN_ADDR <= WORD_ZERO;
      end else begin
         RETIRE <= ISSUE_VALID && !exc;
         IS_NOP <= ISSUE_VALID && dif.kind == OP_NOP;
         REDIRECT <= ISSUE_VALID && is_jump && !exc;
         // Sequential successor is squashed with the jump
         FLUSH_YOUNGER <= ISSUE_VALID && is_jump;
         NEXT_PC <= (is_jump && !exc) ? tgt : link_val;
         MISALIGN_EXC <= exc;
         MISALIGN_ADDR <= tgt;
      end
   end

   // ------------------------------------------------------------
   // Target fault attribution
   // ------------------------------------------------------------
   // Fault reported on the fetch after the jump, with the target pc
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         pending_tgt_q <= 1'b0;
         pending_pc_q <= WORD_ZERO;
         TGT_FAULT_EXC <= 1'b0;
         TGT_FAULT_PC <= WORD_ZERO;
      end else begin
         if (ISSUE_VALID && is_jump && !exc) begin
            pending_tgt_q <= 1'b1;
            pending_pc_q <= tgt;
         end else if (TGT_FETCH_FAULT || TGT_PAGE_FAULT) begin
            pending_tgt_q <= 1'b0;
         end
         TGT_FAULT_EXC <= pending_tgt_q &&
                          (TGT_FETCH_FAULT || TGT_PAGE_FAULT);
         TGT_FAULT_PC <= pending_pc_q;
      end
   end

   // ------------------------------------------------------------
   // Return stack hints
   // ------------------------------------------------------------
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         RAS_PUSH <= 1'b0;
         RAS_POP <= 1'b0;
         RAS_ADDR <= WORD_ZERO;
      end else begin
         RAS_PUSH <= ISSUE_VALID && !exc && push_h;
         RAS_POP <= ISSUE_VALID && !exc && pop_h;
         RAS_ADDR <= link_val;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RESET);

   property p_nop_quiet;
      ISSUE_VALID && ISSUE_INSTR == INSTR_NOP |=>
         IS_NOP && !WB_EN && !REDIRECT && NEXT_PC == $past(ISSUE_PC) + 4;
   endproperty
   a_nop_quiet: assert property (p_nop_quiet)
      else $error("nop changed state");

   property p_jal_target;
      ISSUE_VALID && ISSUE_INSTR[6:0] == OPC_JAL && !half_q &&
         jal_tgt[1:0] == 2'b00 |=> REDIRECT && FLUSH_YOUNGER &&
         NEXT_PC == $past(ISSUE_PC) + $past(dif.imm_j);
   endproperty
   a_jal_target: assert property (p_jal_target)
      else $error("jal target wrong");

   property p_link;
      ISSUE_VALID && is_jump && !exc && dif.rd != 5'h00 |=>
         WB_EN && WB_DATA == $past(ISSUE_PC) + 4;
   endproperty
   a_link: assert property (p_link)
      else $error("link value wrong");

   property p_x0;
      ISSUE_VALID && dif.rd == 5'h00 |=> !WB_EN;
   endproperty
   a_x0: assert property (p_x0)
      else $error("x0 written");

   property p_jalr_bit0;
      REDIRECT && !$past(dif.kind == OP_JAL) |-> NEXT_PC[0] == 1'b0 &&
         NEXT_PC[31:1] == $past(RS1_DATA[31:1] + dif.imm_i[31:1] +
         {30'h0, RS1_DATA[0] & dif.imm_i[0]});
   endproperty
   a_jalr_bit0: assert property (p_jalr_bit0)
      else $error("jalr target wrong");

   property p_misalign;
      ISSUE_VALID && is_jump && tgt[1] && !half_q |=>
         MISALIGN_EXC && !REDIRECT && !WB_EN;
   endproperty
   a_misalign: assert property (p_misalign)
      else $error("misalign missed");

   property p_half_mode;
      $past(half_q) |-> !MISALIGN_EXC;
   endproperty
   a_half_mode: assert property (p_half_mode)
      else $error("misalign in half mode");

   property p_jalr_hints;
      ISSUE_VALID && dif.kind == OP_JALR && !exc &&
         is_link(dif.rs1) && dif.rs1 == dif.rd |=> RAS_PUSH && !RAS_POP;
   endproperty
   a_jalr_hints: assert property (p_jalr_hints)
      else $error("same link reg popped");

   property p_pop_push;
      ISSUE_VALID && dif.kind == OP_JALR && !exc && is_link(dif.rs1) &&
         is_link(dif.rd) && dif.rs1 != dif.rd |=> RAS_PUSH && RAS_POP;
   endproperty
   a_pop_push: assert property (p_pop_push)
      else $error("coroutine hint wrong");

   property p_jal_push;
      ISSUE_VALID && dif.kind == OP_JAL && !exc |=>
         RAS_PUSH == $past(is_link(dif.rd)) && !RAS_POP;
   endproperty
   a_jal_push: assert property (p_jal_push)
      else $error("jal hint wrong");

   property p_fault_target;
      TGT_FAULT_EXC |-> TGT_FAULT_PC == $past(pending_pc_q) &&
         $past(pending_tgt_q);
   endproperty
   a_fault_target: assert property (p_fault_target)
      else $error("fault pc wrong");

   // Reserved indirect-jump encodings retire as plain instructions
   property p_illegal_jalr;
      ISSUE_VALID && dif.illegal_jalr |=> !REDIRECT && !FLUSH_YOUNGER &&
         !WB_EN && !RAS_PUSH && !RAS_POP;
   endproperty
   a_illegal_jalr: assert property (p_illegal_jalr)
      else $error("reserved jalr jumped");

   c_jal: cover property (REDIRECT && RAS_PUSH);
   c_pop_push: cover property (RAS_PUSH && RAS_POP);
   c_misalign: cover property (MISALIGN_EXC);
   c_nop: cover property (IS_NOP);
   c_fault: cover property (TGT_FAULT_EXC);

endmodule : jump_link_nop_unit
`default_nettype wire

// >>> fetch_fault_model.sv
// Fetch-side model that reports faults on jump targets
`timescale 1ns/1ps
`default_nettype none
module fetch_fault_model (
   // Clock
   input wire logic clk,
   // Fault request and jump seen
   input wire logic [1:0] fault_kind,
   input wire logic redirect,
   // Fault lines
   output logic fetch_fault,
   output logic page_fault
);
   // Target fetch starts one cycle after the redirect
   always_ff @(posedge clk) begin
      fetch_fault <= redirect && fault_kind == 2'h1;
      page_fault <= redirect && fault_kind == 2'h2;
   end
endmodule : fetch_fault_model
`default_nettype wire

// >>> jump_link_nop_unit_tb_top.sv
// Self-checking bench for the jump, link and no-op execute stage
`timescale 1ns/1ps
`default_nettype none
module jump_link_nop_unit_tb_top;
   import jump_unit_pkg::*;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic half_en = 1'b0;
   logic valid = 1'b0;
   logic [31:0] pc = 32'h0;
   logic [31:0] instr = 32'h0;
   logic [31:0] rs1 = 32'h0;
   logic [1:0] fault_kind = 2'h0;
   logic fetch_fault, page_fault, wb_en, retire, redirect, flush;
   logic is_nop, mis, tfe, push, pop;
   logic [4:0] wb_rd;
   logic [31:0] wb_data, next_pc, mis_addr, tf_pc, ras_addr;
   logic pend = 1'b0;
   logic x_j, x_mis, x_nop, x_push, x_pop;
   logic [4:0] x_rd;
   logic [31:0] x_t, x_pc4;
   logic [4:0] regs [0:3] = '{5'h00, 5'h01, 5'h05, 5'h07};
   logic [6:0] ops [0:3] = '{7'h13, 7'h6f, 7'h67, 7'h33};
   int bad_count = 0;
   int checked = 0;
   integer seed = 32'h9a75e6bf;

   always #12.5 ref_clk = ~ref_clk;

   jump_link_nop_unit dut (.REF_CLK(ref_clk), .RESET(reset),
      .HALF_ALIGN_EN(half_en), .ISSUE_VALID(valid), .ISSUE_PC(pc),
      .ISSUE_INSTR(instr), .RS1_DATA(rs1), .WB_EN(wb_en), .WB_RD(wb_rd),
      .WB_DATA(wb_data), .RETIRE(retire), .REDIRECT(redirect),
      .NEXT_PC(next_pc), .FLUSH_YOUNGER(flush), .IS_NOP(is_nop),
      .MISALIGN_EXC(mis), .MISALIGN_ADDR(mis_addr),
      .TGT_FETCH_FAULT(fetch_fault), .TGT_PAGE_FAULT(page_fault),
      .TGT_FAULT_EXC(tfe), .TGT_FAULT_PC(tf_pc), .RAS_PUSH(push),
      .RAS_POP(pop), .RAS_ADDR(ras_addr));

   fetch_fault_model partner (.clk(ref_clk), .fault_kind(fault_kind),
      .redirect(redirect), .fetch_fault(fetch_fault),
      .page_fault(page_fault));

   // ---------------------------------------------------------------
   // Reference model and compare
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic calc(input logic [31:0] p, input logic [31:0] i,
                       input logic [31:0] r);
      logic jal, jr, rdl, rsl;
      jal = i[6:0] == 7'h6f;
      jr = i[6:0] == 7'h67 && i[14:12] == 3'h0;
      x_rd = i[11:7];
      rdl = x_rd == 5'h01 || x_rd == 5'h05;
      rsl = i[19:15] == 5'h01 || i[19:15] == 5'h05;
      x_pc4 = p + 32'h4;
      if (jal) x_t = p + {{12{i[31]}}, i[19:12], i[20], i[30:21], 1'b0};
      else x_t = (r + {{20{i[31]}}, i[31:20]}) & ~32'h1;
      x_j = jal || jr;
      x_mis = x_j && x_t[1:0] != 2'h0 && !half_en;
      x_nop = i == 32'h00000013;
      x_push = x_j && !x_mis && rdl;
      x_pop = jr && !x_mis && rsl && !(rdl && x_rd == i[19:15]);
   endtask : calc

   task automatic cmp();
      chk("retire", !x_mis, retire);
      chk("redirect", x_j && !x_mis, redirect);
      chk("flush", x_j, flush);
      if (x_j && !x_mis) chk("next_pc", x_t, next_pc);
      if (!x_j) chk("next_pc", x_pc4, next_pc);
      chk("wb_en", x_j && !x_mis && x_rd != 5'h00, wb_en);
      if (x_j && !x_mis && x_rd != 5'h00) begin
         chk("wb_rd", x_rd, wb_rd);
         chk("wb_data", x_pc4, wb_data);
      end
      chk("is_nop", x_nop, is_nop);
      chk("misalign", x_mis, mis);
      if (x_mis) chk("mis_addr", x_t, mis_addr);
      chk("push", x_push, push);
      chk("pop", x_pop, pop);
      if (x_push) chk("ras_addr", x_pc4, ras_addr);
      chk("tgt_fault", 1'b0, tfe);
   endtask : cmp

   // Drive at one edge, compare the issue of the edge before
   task automatic step(input logic v, input logic [31:0] p,
                       input logic [31:0] i, input logic [31:0] r);
      @(posedge ref_clk);
      valid <= v;
      pc <= p;
      instr <= i;
      rs1 <= r;
      #1;
      if (pend) cmp();
      pend = v;
      if (v) calc(p, i, r);
   endtask : step

   task automatic print_verdict();
      $display("TB: checked=%0d bad_count=%0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : print_verdict

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial begin
      logic [31:0] i;
      logic [4:0] a;
      logic [4:0] b;
      int n;
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      step(1'b0, 32'h0, 32'h0, 32'h0);
      step(1'b1, 32'h100, 32'h00000013, 32'h0);
      step(1'b1, 32'h104, 32'h00100013, 32'h0);
      step(1'b1, 32'h108, 32'h008000ef, 32'h0);
      // All register pairings, both jump forms, back to back
      for (int x = 0; x < 16; x++) begin
         a = regs[x % 4];
         b = regs[x / 4];
         step(1'b1, 32'h200 + 32'(x * 8), {12'hff8, b, 3'h0, a, 7'h67},
              32'h1000);
         step(1'b1, 32'h204 + 32'(x * 8), {20'h80000, a, 7'h6f}, 32'h0);
      end
      $display("TB: test hints done");
      for (int h = 0; h < 2; h++) begin
         half_en <= h[0];
         step(1'b0, 32'h0, 32'h0, 32'h0);
         step(1'b0, 32'h0, 32'h0, 32'h0);
         for (int k = 0; k < 80; k++) begin
            i = $random(seed);
            i[6:0] = ops[{$random(seed)} % 4];
            i[11:7] = regs[{$random(seed)} % 4];
            i[19:15] = regs[{$random(seed)} % 4];
            if (k % 3 == 0) i[14:12] = 3'h0;
            step(1'b1, {$random(seed)} & ~32'h1, i, $random(seed));
         end
         $display("TB: test random half=%0d done", h);
      end
      // Faults at the target of a jump
      for (int f = 1; f < 3; f++) begin
         // Drain redirects of earlier jumps so no stray fault is armed
         repeat (2) step(1'b0, 32'h0, 32'h0, 32'h0);
         fault_kind <= 2'(f);
         step(1'b1, 32'h300, 32'h010000ef, 32'h0);
         step(1'b0, 32'h0, 32'h0, 32'h0);
         n = 0;
         while (tfe !== 1'b1 && n < 6) begin
            @(posedge ref_clk);
            #1;
            n++;
         end
         chk("tgt_fault_seen", 1'b1, tfe);
         chk("tgt_fault_pc", 32'h310, tf_pc);
         fault_kind <= 2'h0;
         repeat (2) step(1'b0, 32'h0, 32'h0, 32'h0);
      end
      $display("TB: test target faults done");
      print_verdict();
   end
endmodule : jump_link_nop_unit_tb_top
`default_nettype wire
